// ===== core/cfs_top.sv
// fifo base address and per fifo flag registers on an axi4-lite slave
// assumes the protocol engine drives occupancy synchronous to sys_clk_in
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`include "cfs_map.svh"
`default_nettype none
module cfs_top #(
   parameter int NUM_FIFO = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire cfs_pkg::cfs_occ_t [NUM_FIFO-1:0] occ_in,
   input wire logic [NUM_FIFO*16-1:0] buf_sizes_in,
   output logic [31:0] buffer_base_addr_out,
   output logic irq_out
);
   import cfs_pkg::*;
   // ==========================================================
   // registers
   logic [2:0] operating_mode_field;
   logic [31:0] buffer_base_addr;
   logic [4:0] fifo_sel;
   logic [NUM_FIFO-1:0] irq_stat;
   logic [NUM_FIFO-1:0] irq_mask;
   logic aw_held, w_held;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic calc_start;
   cfs_flags_t [NUM_FIFO-1:0] flags;
   logic [NUM_FIFO-1:0] ovfl_ev;
   logic [NUM_FIFO-1:0] clr_ovfl;
   logic calc_busy;
   logic [31:0] calc_addr;
   // ==========================================================
   // write decode
   wire aw_ctrl = aw_addr == `CFS_OFS_CTRL;
   wire aw_base = aw_addr == `CFS_OFS_BASE;
   wire aw_sel = aw_addr == `CFS_OFS_SEL;
   wire aw_flags = aw_addr == `CFS_OFS_FLAGS;
   wire aw_stat = aw_addr == `CFS_OFS_IRQ_STAT;
   wire aw_mask = aw_addr == `CFS_OFS_IRQ_MASK;
   wire aw_calc = aw_addr == `CFS_OFS_CALC;
   wire aw_result = aw_addr == `CFS_OFS_ADDR;
   wire aw_mapped = aw_ctrl || aw_base || aw_sel || aw_flags || aw_stat || aw_mask || aw_calc
      || aw_result;
   wire wr_go = aw_held && w_held && !s_axi_bvalid_out;
   wire wr_ctrl = wr_go && aw_ctrl;
   wire wr_base = wr_go && aw_base;
   wire wr_sel = wr_go && aw_sel;
   wire wr_flags = wr_go && aw_flags;
   wire wr_mask = wr_go && aw_mask;
   wire wr_calc = wr_go && aw_calc;
   wire wr_known = wr_go && aw_mapped;
   wire in_config = operating_mode_field == `CFS_MODE_CONFIG;
   wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [31:0] base_merged = (buffer_base_addr & ~strb_mask) | (w_data & strb_mask);
   wire sel_ok = fifo_sel < 5'(NUM_FIFO);
   wire [$clog2(NUM_FIFO)-1:0] sel_idx = fifo_sel[$clog2(NUM_FIFO)-1:0];
   // ==========================================================
   // read decode
   wire rd_go = s_axi_arvalid_in && s_axi_arready_out;
   wire rd_stat = rd_go && s_axi_araddr_in == `CFS_OFS_IRQ_STAT;
   wire [31:0] sel_flags = sel_ok ? {22'h0, flags[sel_idx]} : 32'h0000_0000;
   wire ar_ctrl = s_axi_araddr_in == `CFS_OFS_CTRL;
   wire ar_base = s_axi_araddr_in == `CFS_OFS_BASE;
   wire ar_sel = s_axi_araddr_in == `CFS_OFS_SEL;
   wire ar_flags = s_axi_araddr_in == `CFS_OFS_FLAGS;
   wire ar_stat = s_axi_araddr_in == `CFS_OFS_IRQ_STAT;
   wire ar_mask = s_axi_araddr_in == `CFS_OFS_IRQ_MASK;
   wire ar_calc = s_axi_araddr_in == `CFS_OFS_CALC;
   wire ar_result = s_axi_araddr_in == `CFS_OFS_ADDR;
   wire [31:0] rd_word =
      ar_ctrl ? 32'(operating_mode_field) << `CFS_MODE_LSB :
      ar_base ? buffer_base_addr :
      ar_sel ? 32'(fifo_sel) :
      ar_flags ? sel_flags :
      ar_stat ? 32'(irq_stat) :
      ar_mask ? 32'(irq_mask) :
      ar_calc ? 32'(calc_busy) :
      ar_result ? calc_addr : 32'h0000_0000;
   wire rd_known = ar_ctrl || ar_base || ar_sel || ar_flags || ar_stat || ar_mask || ar_calc
      || ar_result;
   // ==========================================================
   // handshake next state
   wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
   wire w_take = s_axi_wvalid_in && s_axi_wready_out;
   wire next_aw_held = aw_take || (aw_held && !wr_go);
   wire next_w_held = w_take || (w_held && !wr_go);
   wire next_bvalid = wr_go || (s_axi_bvalid_out && !s_axi_bready_in);
   wire next_rvalid = rd_go || (s_axi_rvalid_out && !s_axi_rready_in);
   // no new write is taken while its answer waits
   wire next_awready = !next_aw_held && !next_bvalid;
   wire next_wready = !next_w_held && !next_bvalid;
   wire next_arready = !next_rvalid;
   // ==========================================================
   // write address capture
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
      end else begin
         aw_held <= next_aw_held;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr_in;
         end
      end
   end
   // ==========================================================
   // write data capture
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         w_held <= next_w_held;
         if (w_take) begin
            w_data <= s_axi_wdata_in;
            w_strb <= s_axi_wstrb_in;
         end
      end
   end
   // ==========================================================
   // registered readies
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_arready_out <= 1'b0;
      end else begin
         s_axi_awready_out <= next_awready;
         s_axi_wready_out <= next_wready;
         s_axi_arready_out <= next_arready;
      end
   end
   // ==========================================================
   // write response
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= `CFS_RESP_OKAY;
      end else begin
         s_axi_bvalid_out <= next_bvalid;
         if (wr_go) begin
            s_axi_bresp_out <= wr_known ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
         end
      end
   end
   // ==========================================================
   // operating mode
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         operating_mode_field <= `CFS_MODE_RESET;
      end else if (wr_ctrl && w_strb[`CFS_MODE_LSB / 8]) begin
         operating_mode_field <= w_data[`CFS_MODE_MSB:`CFS_MODE_LSB];
      end
   end
   // base address, config mode only
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         buffer_base_addr <= 32'h0000_0000;
      end else if (wr_base && in_config) begin
         buffer_base_addr <= base_merged & `CFS_BASE_KEEP;
      end
   end
   // fifo select
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         fifo_sel <= 5'h00;
      end else if (wr_sel && w_strb[0]) begin
         fifo_sel <= w_data[$bits(fifo_sel)-1:0];
      end
   end
   // interrupt mask
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_mask <= '0;
      end else if (wr_mask) begin
         irq_mask <= w_data[NUM_FIFO-1:0];
      end
   end
   // address walk start pulse
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         calc_start <= 1'b0;
      end else begin
         calc_start <= wr_calc && !calc_busy;
      end
   end
   // software clears overflow with a one at its bit; other flag bits ignore writes
   always_comb begin
      clr_ovfl = '0;
      if (wr_flags && sel_ok && w_strb[0] && (w_data & `CFS_W1C_CLR_OVFL) != 32'h0) begin
         clr_ovfl[sel_idx] = 1'b1;
      end
   end
   // ==========================================================
   // interrupt status: set on overflow, cleared by reading, set wins
   wire [NUM_FIFO-1:0] next_irq_stat = (rd_stat ? '0 : irq_stat) | ovfl_ev;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end
   // level interrupt from unmasked status
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(next_irq_stat & irq_mask);
      end
   end
   // ==========================================================
   // read valid
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_rvalid_out <= 1'b0;
      end else begin
         s_axi_rvalid_out <= next_rvalid;
      end
   end
   // read data and response
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= `CFS_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rdata_out <= rd_word;
         s_axi_rresp_out <= rd_known ? `CFS_RESP_OKAY : `CFS_RESP_SLVERR;
      end
   end
   // ==========================================================
   // base address out to the ram master
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         buffer_base_addr_out <= 32'h0000_0000;
      end else begin
         buffer_base_addr_out <= buffer_base_addr;
      end
   end
   // ==========================================================
   // per fifo flag units
   for (genvar i = 0; i < NUM_FIFO; i++) begin : g_fifo
      cfs_fifo_flags u_flags (
         .sys_clk_in(sys_clk_in),
         .rst_in(rst_in),
         .occ_in(occ_in[i]),
         .clr_ovfl_in(clr_ovfl[i]),
         .flags_out(flags[i]),
         .ovfl_event_out(ovfl_ev[i])
      );
   end
   cfs_addr_calc #(.NUM_FIFO(NUM_FIFO)) u_calc (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .start_in(calc_start),
      .index_in(fifo_sel),
      .base_in(buffer_base_addr),
      .sizes_in(buf_sizes_in),
      .busy_out(calc_busy),
      .addr_out(calc_addr)
   );
endmodule
`default_nettype wire

// ===== core/cfs_map.svh
// register offsets, field positions, reset values and fixed codes of the fifo base and flag block
// assumes the includer places it ahead of any module that reads these names
// Operation
// - one 32-bit base address locates every message buffer.
// - a buffer address is base plus sizes of all buffers before it.
// - the base value is used as a physical address for ram access.
// - base bits 1:0 read zero and ignore writes, word aligning messages.
// - base writes are accepted only while the operating mode is configuration.
// - transmit fifo: bit 9 set while at most half full.
// - transmit fifo: bit 8 set while empty, clear when a message is queued.
// - receive fifo: bit 3 set once an overflow has occurred.
// - receive fifo: bit 2 set while completely full.
// - receive fifo: bit 1 set while at least half full.
// - receive fifo: bit 0 set while at least one message is held.
// - flags of the other direction read zero.
// - occupancy flags are live and read-only; writes to them are ignored.
`ifndef CFS_MAP_SVH
`define CFS_MAP_SVH
// ==========================================================
// register byte addresses
`define CFS_OFS_CTRL 12'h000
`define CFS_OFS_BASE 12'h004
`define CFS_OFS_SEL 12'h008
`define CFS_OFS_FLAGS 12'h00c
`define CFS_OFS_IRQ_STAT 12'h010
`define CFS_OFS_IRQ_MASK 12'h014
`define CFS_OFS_CALC 12'h018
`define CFS_OFS_ADDR 12'h01c
// ==========================================================
// fields
`define CFS_MODE_LSB 21
`define CFS_MODE_MSB 23
`define CFS_MODE_CONFIG 3'h4
`define CFS_MODE_RESET 3'h4
`define CFS_BASE_KEEP 32'hffff_fffc
`define CFS_BIT_TX_HALF 9
`define CFS_BIT_TX_EMPTY 8
`define CFS_BIT_RX_OVFL 3
`define CFS_BIT_RX_FULL 2
`define CFS_BIT_RX_HALF 1
`define CFS_BIT_RX_NEMPTY 0
`define CFS_FLAG_BITS 10
`define CFS_W1C_CLR_OVFL 32'h0000_0008
`define CFS_RESP_OKAY 2'h0
`define CFS_RESP_SLVERR 2'h2
`endif

// ===== core/cfs_pkg.sv
// types shared by the fifo base and flag block
// assumes cfs_map.svh is compiled with it
`default_nettype none
package cfs_pkg;
   // ==========================================================
   // per fifo flag word
   typedef struct packed {
      logic tx_half_empty_flag;
      logic tx_empty_flag;
      logic [3:0] unused;
      logic rx_overflow_flag;
      logic rx_full_flag;
      logic rx_half_full_flag;
      logic rx_not_empty_flag;
   } cfs_flags_t;
   // occupancy report from the protocol engine
   typedef struct packed {
      logic [5:0] count;
      logic [5:0] depth;
      logic fifo_direction_transmit;
      logic rx_arrive;
   } cfs_occ_t;
   typedef enum logic [1:0] {
      CFS_IDLE = 2'b00,
      CFS_WORK = 2'b01,
      CFS_DONE = 2'b11
   } cfs_calc_t;
endpackage
`default_nettype wire

// ===== core/cfs_fifo_flags.sv
// live flags and sticky overflow of one fifo
// assumes occupancy inputs are synchronous to sys_clk_in
`include "cfs_map.svh"
`default_nettype none
module cfs_fifo_flags (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire cfs_pkg::cfs_occ_t occ_in,
   input wire logic clr_ovfl_in,
   output cfs_pkg::cfs_flags_t flags_out,
   output logic ovfl_event_out
);
   import cfs_pkg::*;
   logic ovfl;
   wire tx = occ_in.fifo_direction_transmit;
   wire is_full = occ_in.count >= occ_in.depth;
   wire at_half = {occ_in.count, 1'b0} >= {1'b0, occ_in.depth};
   wire is_empty = occ_in.count == 6'h00;
   wire ovfl_hit = !tx && occ_in.rx_arrive && is_full;
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ovfl <= 1'b0;
      end else if (ovfl_hit) begin
         ovfl <= 1'b1;
      end else if (clr_ovfl_in || tx) begin
         ovfl <= 1'b0;
      end
   end
   assign ovfl_event_out = ovfl_hit;
   always_comb begin
      flags_out = '0;
      flags_out.tx_half_empty_flag = tx && ({occ_in.count, 1'b0} <= {1'b0, occ_in.depth});
      flags_out.tx_empty_flag = tx && is_empty;
      flags_out.rx_overflow_flag = !tx && ovfl;
      flags_out.rx_full_flag = !tx && is_full;
      flags_out.rx_half_full_flag = !tx && at_half;
      flags_out.rx_not_empty_flag = !tx && !is_empty;
   end
endmodule
`default_nettype wire

// ===== core/cfs_addr_calc.sv
// walks buffer sizes to find one buffer's physical address
// assumes sizes arrive as a flat vector of byte counts
`include "cfs_map.svh"
`default_nettype none
module cfs_addr_calc #(
   parameter int NUM_FIFO = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire logic [4:0] index_in,
   input wire logic [31:0] base_in,
   input wire logic [NUM_FIFO*16-1:0] sizes_in,
   output logic busy_out,
   output logic [31:0] addr_out
);
   import cfs_pkg::*;
   cfs_calc_t state;
   logic [4:0] step;
   logic [31:0] acc;
   wire [15:0] cur_size = sizes_in[step[$clog2(NUM_FIFO)-1:0]*16 +: 16];
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state <= CFS_IDLE;
         step <= 5'h00;
         acc <= 32'h0000_0000;
      end else begin
         case (state)
            CFS_IDLE: begin
               if (start_in) begin
                  acc <= base_in;
                  step <= 5'h00;
                  state <= CFS_WORK;
               end
            end
            CFS_WORK: begin
               if (step >= index_in) begin
                  state <= CFS_DONE;
               end else begin
                  acc <= acc + {16'h0000, cur_size};
                  step <= step + 5'h01;
               end
            end
            CFS_DONE: state <= CFS_IDLE;
            default: state <= CFS_IDLE;
         endcase
      end
   end
   assign busy_out = state != CFS_IDLE;
   assign addr_out = acc;
endmodule
`default_nettype wire

// ===== testbench/cfs_monitor.sv
// concurrent checks on the cfs_top register bus and outputs
// assumes it is bound to cfs_top by the statement at the foot
`default_nettype none
module cfs_monitor #(
   parameter int NUM_FIFO = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [31:0] buffer_base_addr_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====
   // checks
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   a_base_align: assert property (buffer_base_addr_out[1:0] == 2'h0)
      else $error("base low bits set");
   a_base_write: assert property (!$stable(buffer_base_addr_out) && !$past(rst_in)
      && !$past(rst_in, 2) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
      else $error("base changed without a write");
   a_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
      && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
   a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_wr_refuse: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while answering");
   a_rd_refuse: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read taken while answering");
   a_wr_once: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write answered twice");
   a_rd_once: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
      else $error("read answered twice");
   a_reset_idle: assert property ($past(rst_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out
      && !irq_out) else $error("outputs busy after reset");
endmodule
bind cfs_top cfs_monitor #(.NUM_FIFO(NUM_FIFO)) cfs_monitor_inst (.sys_clk_in, .rst_in,
   .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
   .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
   .s_axi_rvalid_out, .s_axi_rready_in, .buffer_base_addr_out, .irq_out);
`default_nettype wire

// ===== testbench/cfs_eng_model.sv
// behavioural protocol engine: two fifos filled by bench pushes
// assumes push pulses last one cycle
`default_nettype none
module cfs_eng_model
   import cfs_pkg::*;
#(
   parameter int DEPTH = 4
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [1:0] dir_in,
   input wire logic [1:0] push_in,
   output cfs_pkg::cfs_occ_t [1:0] occ_out,
   output logic [31:0] sizes_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [5:0] cnt [2];
   // ====
   // occupancy
   assign sizes_out = {16'h0020, 16'h0040};
   for (genvar i = 0; i < 2; i++) begin : g_f
      // arrival pulse in receive mode, count saturates at depth
      assign occ_out[i] = {cnt[i], 6'(DEPTH), dir_in[i], push_in[i] & ~dir_in[i]};
      always_ff @(posedge sys_clk_in) begin
         if (rst_in) cnt[i] <= 6'h00;
         else if (push_in[i] && cnt[i] < 6'(DEPTH)) cnt[i] <= cnt[i] + 6'h01;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for cfs_top
// assumes fifo 0 transmit, fifo 1 receive, depth 4
`include "cfs_map.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import cfs_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, base, sizes;
   logic awrdy, wrdy, bv, arrdy, rv, irq;
   logic [1:0] br, rr, rs, push = 0;
   cfs_occ_t [1:0] occ;
   int err_count = 0, compares = 0, cyc = 0;
   cfs_top #(.NUM_FIFO(2)) cfs_top_inst (.sys_clk_in(clk), .rst_in(rst),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awrdy),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(1'b1), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arrdy), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1), .occ_in(occ),
      .buf_sizes_in(sizes), .buffer_base_addr_out(base), .irq_out(irq));
   cfs_eng_model cfs_eng_model_inst (.sys_clk_in(clk), .rst_in(rst), .dir_in(2'b01),
      .push_in(push), .occ_out(occ), .sizes_out(sizes));
   // ====
   // bus tasks
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s exp %h got %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic wchk(input string n, input logic [11:0] a, input logic [31:0] d,
      input logic [1:0] e);
      logic ad, dd;
      ad = 0;
      dd = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      while (!(ad && dd)) begin
         @(posedge clk);
         if (awrdy) awv <= 0;
         if (wrdy) wv <= 0;
         ad = ad | awrdy;
         dd = dd | wrdy;
      end
      do @(posedge clk); while (!bv);
      chk(n, 32'(e), 32'(br));
   endtask
   task automatic rdx(input logic [11:0] a, output logic [31:0] d);
      ara <= a;
      arv <= 1;
      do @(posedge clk); while (!arrdy);
      arv <= 0;
      do @(posedge clk); while (!rv);
      d = rd;
      rs = rr;
   endtask
   task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      rdx(a, d);
      chk(n, e, d);
   endtask
   task automatic push_msg(input int f);
      push[f] <= 1;
      @(posedge clk);
      push[f] <= 0;
      @(posedge clk);
   endtask
   // ====
   // scenarios
   task automatic t_reset;
      logic [31:0] d;
      rchk("base", `CFS_OFS_BASE, 32'h0);
      rdx(`CFS_OFS_CTRL, d);
      chk("mode", 32'(`CFS_MODE_RESET), 32'(d[23:21]));
      rchk("mask", `CFS_OFS_IRQ_MASK, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_base;
      wchk("base wr", `CFS_OFS_BASE, 32'h1234_5677, `CFS_RESP_OKAY);
      rchk("base", `CFS_OFS_BASE, 32'h1234_5674);
      chk("base pin", 32'h1234_5674, base);
      wchk("run", `CFS_OFS_CTRL, 32'h0, `CFS_RESP_OKAY);
      wchk("base run", `CFS_OFS_BASE, 32'h5555_0000, `CFS_RESP_OKAY);
      rchk("base kept", `CFS_OFS_BASE, 32'h1234_5674);
      wchk("cfg", `CFS_OFS_CTRL, 32'h0080_0000, `CFS_RESP_OKAY);
      wchk("unmapped", 12'h020, 32'h0, `CFS_RESP_SLVERR);
      wchk("misaligned", 12'h006, 32'h0, `CFS_RESP_SLVERR);
      rchk("unmapped rd", 12'h020, 32'h0);
      chk("rd resp err", 32'(`CFS_RESP_SLVERR), 32'(rs));
      rchk("base again", `CFS_OFS_BASE, 32'h1234_5674);
      chk("rd resp ok", 32'(`CFS_RESP_OKAY), 32'(rs));
      $display("test base done");
   endtask
   task automatic t_addr;
      logic [31:0] d;
      for (int i = 0; i < 2; i++) begin
         wchk("sel", `CFS_OFS_SEL, 32'(i), `CFS_RESP_OKAY);
         wchk("start", `CFS_OFS_CALC, 32'h1, `CFS_RESP_OKAY);
         d = 32'h1;
         for (int n = 0; n < 20 && d[0]; n++) rdx(`CFS_OFS_CALC, d);
         chk("busy", 32'h0, 32'(d[0]));
         rchk("addr", `CFS_OFS_ADDR, 32'h1234_5674 + 32'(i) * 32'h40);
      end
      $display("test addr done");
   endtask
   task automatic t_tx;
      wchk("sel none", `CFS_OFS_SEL, 32'h5, `CFS_RESP_OKAY);
      rchk("no fifo", `CFS_OFS_FLAGS, 32'h0);
      wchk("sel", `CFS_OFS_SEL, 32'h0, `CFS_RESP_OKAY);
      for (int c = 0; c <= 4; c++) begin
         rchk("tx", `CFS_OFS_FLAGS, 32'(2 * c <= 4) << 9 | 32'(c == 0) << 8);
         push_msg(0);
      end
      $display("test tx done");
   endtask
   task automatic t_rx;
      logic [31:0] d;
      wchk("sel", `CFS_OFS_SEL, 32'h1, `CFS_RESP_OKAY);
      for (int c = 0; c <= 4; c++) begin
         rchk("rx", `CFS_OFS_FLAGS, 32'(c == 4) << 2 | 32'(2 * c >= 4) << 1 | 32'(c > 0));
         if (c < 4) push_msg(1);
      end
      wchk("flags wr", `CFS_OFS_FLAGS, 32'h0, `CFS_RESP_OKAY);
      rchk("flags ro", `CFS_OFS_FLAGS, 32'h7);
      push_msg(1);
      rchk("ovfl", `CFS_OFS_FLAGS, 32'hf);
      chk("irq masked", 32'h0, 32'(irq));
      rchk("status", `CFS_OFS_IRQ_STAT, 32'h2);
      rchk("status clr", `CFS_OFS_IRQ_STAT, 32'h0);
      push_msg(1);
      wchk("mask", `CFS_OFS_IRQ_MASK, 32'h2, `CFS_RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("irq on", 32'h1, 32'(irq));
      rdx(`CFS_OFS_IRQ_STAT, d);
      repeat (2) @(posedge clk);
      chk("irq off", 32'h0, 32'(irq));
      rchk("sticky", `CFS_OFS_FLAGS, 32'hf);
      wchk("clr", `CFS_OFS_FLAGS, `CFS_W1C_CLR_OVFL, `CFS_RESP_OKAY);
      rchk("ovfl gone", `CFS_OFS_FLAGS, 32'h7);
      $display("test rx done");
   endtask
   // ====
   // run control
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      t_reset();
      t_base();
      t_addr();
      t_tx();
      t_rx();
      close_out();
   end
endmodule
`default_nettype wire
